//--- pkg/scp_pkg.sv
// Package: constants, register map and types of the serial command port
package scp_pkg;
   localparam int unsigned CLK_HZ        = 40000000;
   localparam int unsigned BAUD          = 19200;
   localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
   localparam int unsigned DATA_BITS     = 8;
   localparam logic [7:0]  CH_LF         = 8'h0A;
   localparam logic [7:0]  CH_CR         = 8'h0D;
   localparam int unsigned CMD_DEPTH     = 64;
   // Event status bit positions (weights 4, 8, 16, 32)
   localparam int unsigned ESR_QRY       = 2;
   localparam int unsigned ESR_DEV       = 3;
   localparam int unsigned ESR_EXE       = 4;
   localparam int unsigned ESR_CMD       = 5;
   localparam logic [7:0]  ESR_MASK      = 8'h3C;
   // Register byte offsets
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_STAT      = 8'h04;
   localparam logic [7:0]  REG_CMDLEN    = 8'h08;
   localparam logic [7:0]  REG_CMDDAT    = 8'h0C;
   localparam logic [7:0]  REG_TXDAT     = 8'h10;
   localparam logic [7:0]  REG_ESR       = 8'h14;
   localparam logic [7:0]  REG_IRQ_STAT  = 8'h18;
   localparam logic [7:0]  REG_IRQ_MASK  = 8'h1C;
   localparam logic [7:0]  REG_CFG       = 8'h20;
   localparam logic [7:0]  REG_ERRCODE   = 8'h24;
   // Control register bits
   localparam int unsigned CTRL_DONE     = 0;
   localparam int unsigned CTRL_CLS      = 1;
   localparam int unsigned CTRL_QERR     = 2;
   localparam int unsigned CTRL_DERR     = 3;
   localparam int unsigned CTRL_XERR     = 4;
   localparam int unsigned CTRL_SERR     = 5;
   localparam int unsigned CTRL_TXEOL    = 6;
   // Interrupt bits
   localparam int unsigned IRQ_CMD       = 0;
   localparam int unsigned IRQ_OVR       = 1;
   localparam int unsigned IRQ_TXE       = 2;
   localparam logic [2:0]  IRQ_RST       = 3'h0;
   localparam logic [15:0] ERR_COMM      = 16'hFF9C;
   typedef enum logic [1:0] {AXI_OKAY = 2'b00, AXI_SLVERR = 2'b10} scp_resp_e;
endpackage

//--- pkg/scp_byte_if.sv
// Interface: byte stream with valid and ready between internal modules
`timescale 1ns/1ps
interface scp_byte_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- rtl/scp_uart_rx.sv
// Receiver: 8N1 deserialiser producing one byte per frame whose stop bit is high
`timescale 1ns/1ps
module scp_uart_rx #(
   parameter int unsigned BIT_CYC = scp_pkg::BIT_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Line
   input  wire logic rxd,
   // Byte out; sink always ready, overrun detected downstream
   scp_byte_if.src   out
);
   logic [15:0] cnt_ff;
   logic [3:0]  bit_ff;
   logic [7:0]  sh_ff;
   logic        busy_ff;
   logic        s1_ff;
   logic        s2_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
      end else if (ce) begin
         s1_ff <= rxd;
         s2_ff <= s1_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff    <= 16'h0000;
         bit_ff    <= 4'h0;
         sh_ff     <= 8'h00;
         busy_ff   <= 1'b0;
         out.valid <= 1'b0;
         out.data  <= 8'h00;
      end else if (ce) begin
         out.valid <= 1'b0;
         if (!busy_ff) begin
            if (!s2_ff) begin
               // Sample in mid-bit: start at half a bit
               busy_ff <= 1'b1;
               cnt_ff  <= 16'(BIT_CYC / 2);
               bit_ff  <= 4'h0;
            end
         end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
         end else begin
            cnt_ff <= 16'(BIT_CYC - 1);
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == 4'h0) begin
               if (s2_ff) busy_ff <= 1'b0;
            end else if (bit_ff <= 4'(scp_pkg::DATA_BITS)) begin
               sh_ff <= {s2_ff, sh_ff[7:1]};
            end else begin
               busy_ff <= 1'b0;
               if (s2_ff) begin
                  out.valid <= 1'b1;
                  out.data  <= sh_ff;
               end
            end
         end
      end
   end
endmodule

//--- rtl/scp_uart_tx.sv
// Transmitter: 8N1 serialiser taking one byte per handshake
`timescale 1ns/1ps
module scp_uart_tx #(
   parameter int unsigned BIT_CYC = scp_pkg::BIT_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Byte in
   scp_byte_if.snk   in,
   // Line
   output logic      txd
);
   logic [15:0] cnt_ff;
   logic [3:0]  bit_ff;
   logic [9:0]  sh_ff;
   logic        busy_ff;

   assign in.ready = !busy_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff  <= 16'h0000;
         bit_ff  <= 4'h0;
         sh_ff   <= 10'h3FF;
         busy_ff <= 1'b0;
         txd     <= 1'b1;
      end else if (ce) begin
         if (!busy_ff) begin
            txd <= 1'b1;
            if (in.valid) begin
               sh_ff   <= {1'b1, in.data, 1'b0};
               busy_ff <= 1'b1;
               bit_ff  <= 4'h0;
               cnt_ff  <= 16'h0000;
            end
         end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
         end else begin
            if (bit_ff == 4'(scp_pkg::DATA_BITS + 2)) begin
               busy_ff <= 1'b0;
            end else begin
               txd    <= sh_ff[0];
               sh_ff  <= {1'b1, sh_ff[9:1]};
               bit_ff <= bit_ff + 4'h1;
               cnt_ff <= 16'(BIT_CYC - 1);
            end
         end
      end
   end
endmodule

//--- rtl/scp_top.sv
// Top: serial command port with AXI4-Lite registers
`timescale 1ns/1ps
module scp_top #(
   parameter int unsigned BIT_CYC   = scp_pkg::BIT_CYC,
   parameter int unsigned CMD_DEPTH = scp_pkg::CMD_DEPTH
) (
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Serial line
   input  wire logic        rxd,
   output logic             txd_ff,
   output logic             dtr_ff,
   // Rear switches
   input  wire logic        sw_sel_ieee,
   input  wire logic [4:0]  sw_addr,
   output logic             ieee_en_ff,
   output logic [4:0]       ieee_addr_ff,
   output logic [15:0]      disp_err_ff,
   output logic             irq_ff,
   // AXI4-Lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   // AXI4-Lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp
);
   localparam int AW = $clog2(CMD_DEPTH);

   scp_byte_if rx_if ();
   scp_byte_if tx_if ();

   logic [7:0]  buf_mem [CMD_DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] cmd_len_ff;
   logic [AW-1:0] rd_idx_ff;
   logic        cmd_rdy_ff;
   logic [7:0]  esr_ff;
   logic [2:0]  irq_stat_ff;
   logic [2:0]  irq_mask_ff;
   logic        sampled_ff;
   logic        txv_ff;
   logic [7:0]  txd_data_ff;
   logic        txd_line;
   logic        eol_pend_ff;
   logic [7:0]  aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   logic        aw_got_ff;
   logic        w_got_ff;
   logic [2:0]  irq_set;
   logic        serial_on;
   logic        rx_char;
   logic        rx_eol;
   logic        wr_go;
   logic        rd_go;
   logic [31:0] ctrl_w;
   logic        wr_ctrl;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction

   scp_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .rxd (rxd),
      .out (rx_if)
   );
   assign rx_if.ready = 1'b1;

   scp_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .in  (tx_if),
      .txd (txd_line)
   );
   assign tx_if.valid = txv_ff;
   assign tx_if.data  = txd_data_ff;

   // Serial path only listens when the switch chose it
   assign serial_on = sampled_ff && !ieee_en_ff;
   assign rx_char   = rx_if.valid && serial_on;
   assign rx_eol    = rx_char && rx_if.data == scp_pkg::CH_LF;

   // Switch capture once after reset release; later changes ignored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sampled_ff   <= 1'b0;
         ieee_en_ff   <= 1'b0;
         ieee_addr_ff <= 5'h00;
      end else if (ce && !sampled_ff) begin
         sampled_ff   <= 1'b1;
         ieee_en_ff   <= sw_sel_ieee;
         ieee_addr_ff <= sw_addr;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) txd_ff <= 1'b1;
      else if (ce) txd_ff <= txd_line;
   end

   // AXI handshakes
   assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign wr_ctrl = wr_go && hit(aw_addr_ff, scp_pkg::REG_CTRL) && w_strb_ff[0];
   assign ctrl_w  = wr_ctrl ? w_data_ff : 32'h0000_0000;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         aw_addr_ff    <= 8'h00;
         w_data_ff     <= 32'h0000_0000;
         w_strb_ff     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= scp_pkg::AXI_OKAY;
      end else if (ce) begin
         s_axi_awready <= !aw_got_ff && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_got_ff && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff  <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_addr_ff > scp_pkg::REG_ERRCODE + 8'h03
                            ? scp_pkg::AXI_SLVERR : scp_pkg::AXI_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Command collection and hold-off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff  <= '0;
         cmd_len_ff <= '0;
         cmd_rdy_ff <= 1'b0;
         dtr_ff     <= 1'b0;
      end else if (ce) begin
         if (rx_char && !cmd_rdy_ff) begin
            if (rx_eol) begin
               cmd_len_ff <= wr_ptr_ff;
               wr_ptr_ff  <= '0;
               cmd_rdy_ff <= 1'b1;
               dtr_ff     <= 1'b1;
            end else if (wr_ptr_ff < (AW+1)'(CMD_DEPTH)) begin
               wr_ptr_ff  <= wr_ptr_ff + 1'b1;
            end
         end else if (ctrl_w[scp_pkg::CTRL_DONE] && cmd_rdy_ff) begin
            cmd_rdy_ff <= 1'b0;
            dtr_ff     <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (ce && rx_char && !cmd_rdy_ff && !rx_eol && wr_ptr_ff < (AW+1)'(CMD_DEPTH))
         buf_mem[wr_ptr_ff[AW-1:0]] <= rx_if.data;
   end

   // Event status and displayed error; errors set over a same-cycle clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         esr_ff      <= 8'h00;
         disp_err_ff <= 16'h0000;
      end else if (ce) begin
         if (ctrl_w[scp_pkg::CTRL_CLS]) begin
            esr_ff      <= 8'h00;
            disp_err_ff <= 16'h0000;
         end
         if (ctrl_w[scp_pkg::CTRL_QERR]) esr_ff[scp_pkg::ESR_QRY] <= 1'b1;
         if (ctrl_w[scp_pkg::CTRL_DERR]) esr_ff[scp_pkg::ESR_DEV] <= 1'b1;
         if (ctrl_w[scp_pkg::CTRL_XERR]) esr_ff[scp_pkg::ESR_EXE] <= 1'b1;
         if (ctrl_w[scp_pkg::CTRL_SERR]) esr_ff[scp_pkg::ESR_CMD] <= 1'b1;
         // Overrun: characters while a command waits are lost
         if (rx_char && cmd_rdy_ff) begin
            esr_ff[scp_pkg::ESR_CMD] <= 1'b1;
            disp_err_ff              <= scp_pkg::ERR_COMM;
         end
      end
   end

   // Transmit path: software writes bytes; line feed sent on CTRL_TXEOL, CR and LF writes dropped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txv_ff      <= 1'b0;
         txd_data_ff <= 8'h00;
         eol_pend_ff <= 1'b0;
      end else if (ce) begin
         if (txv_ff && tx_if.ready) txv_ff <= 1'b0;
         if (wr_go && hit(aw_addr_ff, scp_pkg::REG_TXDAT) && !txv_ff
             && w_strb_ff[0] && w_data_ff[7:0] != scp_pkg::CH_CR
             && w_data_ff[7:0] != scp_pkg::CH_LF) begin
            txv_ff      <= 1'b1;
            txd_data_ff <= w_data_ff[7:0];
         end else if (ctrl_w[scp_pkg::CTRL_TXEOL]) begin
            eol_pend_ff <= 1'b1;
         end else if (eol_pend_ff && !txv_ff) begin
            txv_ff      <= 1'b1;
            txd_data_ff <= scp_pkg::CH_LF;
            eol_pend_ff <= 1'b0;
         end
      end
   end

   // Interrupts: set wins over write-one clear
   assign irq_set = {txv_ff && tx_if.ready, rx_char && cmd_rdy_ff, rx_eol && !cmd_rdy_ff};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_stat_ff <= scp_pkg::IRQ_RST;
         irq_mask_ff <= scp_pkg::IRQ_RST;
         irq_ff      <= 1'b0;
      end else if (ce) begin
         if (wr_go && hit(aw_addr_ff, scp_pkg::REG_IRQ_MASK) && w_strb_ff[0])
            irq_mask_ff <= w_data_ff[2:0];
         if (wr_go && hit(aw_addr_ff, scp_pkg::REG_IRQ_STAT) && w_strb_ff[0])
            irq_stat_ff <= (irq_stat_ff & ~w_data_ff[2:0]) | irq_set;
         else
            irq_stat_ff <= irq_stat_ff | irq_set;
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // Read channel
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= scp_pkg::AXI_OKAY;
         rd_idx_ff     <= '0;
      end else if (ce) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= scp_pkg::AXI_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            case (s_axi_araddr[7:2])
               scp_pkg::REG_CTRL[7:2]:     s_axi_rdata <= 32'h0000_0000;
               scp_pkg::REG_STAT[7:2]:
                  s_axi_rdata <= {28'h0, eol_pend_ff, txv_ff, dtr_ff, cmd_rdy_ff};
               scp_pkg::REG_CMDLEN[7:2]:   s_axi_rdata <= 32'(cmd_len_ff);
               scp_pkg::REG_CMDDAT[7:2]: begin
                  s_axi_rdata <= {24'h0, buf_mem[rd_idx_ff]};
                  rd_idx_ff   <= rd_idx_ff + 1'b1;
               end
               scp_pkg::REG_TXDAT[7:2]:    s_axi_rdata <= 32'h0000_0000;
               scp_pkg::REG_ESR[7:2]:
                  s_axi_rdata <= {24'h0, esr_ff & scp_pkg::ESR_MASK};
               scp_pkg::REG_IRQ_STAT[7:2]: s_axi_rdata <= {29'h0, irq_stat_ff};
               scp_pkg::REG_IRQ_MASK[7:2]: s_axi_rdata <= {29'h0, irq_mask_ff};
               scp_pkg::REG_CFG[7:2]:
                  s_axi_rdata <= {26'h0, ieee_en_ff, ieee_addr_ff};
               scp_pkg::REG_ERRCODE[7:2]:  s_axi_rdata <= {16'h0, disp_err_ff};
               default:                    s_axi_rresp <= scp_pkg::AXI_SLVERR;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (ctrl_w[scp_pkg::CTRL_DONE]) rd_idx_ff <= '0;
      end
   end
endmodule

//--- test/scp_checker.sv
// Checker: concurrent assertions on the serial command port pins
`timescale 1ns/1ps
module scp_checker #(
   parameter int unsigned BIT_CYC = scp_pkg::BIT_CYC
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Serial line and switches
   input wire logic        txd_ff,
   input wire logic        dtr_ff,
   input wire logic        sw_sel_ieee,
   input wire logic [4:0]  sw_addr,
   input wire logic        ieee_en_ff,
   input wire logic [4:0]  ieee_addr_ff,
   input wire logic [15:0] disp_err_ff,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata
);
   logic [31:0] low_cnt_ff;
   logic [1:0]  cap_cnt_ff;
   logic [7:0]  ra_ff;
   logic [7:0]  wa_ff;
   logic [31:0] wd_ff;
   logic [3:0]  since_w_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Low-run length of the line, cycles since switch capture
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_ff <= 32'h0;
         cap_cnt_ff <= 2'h0;
      end else begin
         low_cnt_ff <= txd_ff ? 32'h0 : low_cnt_ff + 32'h1;
         if (cap_cnt_ff != 2'h2) begin
            cap_cnt_ff <= cap_cnt_ff + 2'h1;
         end
      end
   end
   // Last addresses and write data; count saturates so old writes age out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ra_ff      <= 8'h0;
         wa_ff      <= 8'h0;
         wd_ff      <= 32'h0;
         since_w_ff <= 4'hF;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            ra_ff <= s_axi_araddr;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            wa_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_ff      <= s_axi_wdata;
            since_w_ff <= 4'h0;
         end else if (since_w_ff != 4'hF) begin
            since_w_ff <= since_w_ff + 4'h1;
         end
      end
   end
   a_txd_frame: assert property ($rose(txd_ff) |->
      (low_cnt_ff % BIT_CYC == 0) && (low_cnt_ff <= 9 * BIT_CYC))
      else $error("txd low run is not whole bits of one frame");
   a_dtr_release: assert property ($fell(dtr_ff) |-> since_w_ff <= 4'h6 &&
      wa_ff == scp_pkg::REG_CTRL && wd_ff[scp_pkg::CTRL_DONE])
      else $error("hold-off dropped without a done write");
   a_esr_bits: assert property (s_axi_rvalid && ra_ff == scp_pkg::REG_ESR |->
      (s_axi_rdata & ~{24'h0, scp_pkg::ESR_MASK}) == 32'h0)
      else $error("event status read shows unused bits");
   a_cls_clears: assert property (since_w_ff == 4'h8 && wa_ff == scp_pkg::REG_CTRL &&
      wd_ff[scp_pkg::CTRL_CLS] |-> disp_err_ff == 16'h0)
      else $error("displayed error survives clear status");
   a_err_code: assert property (disp_err_ff != 16'h0 |-> disp_err_ff == scp_pkg::ERR_COMM)
      else $error("displayed error code is not the link error");
   a_ieee_addr: assert property (cap_cnt_ff == 2'h1 |->
      ieee_addr_ff == sw_addr && ieee_en_ff == sw_sel_ieee)
      else $error("switches not captured after reset");
   a_serial_off: assert property (ieee_en_ff |-> !$rose(dtr_ff))
      else $error("serial path active in bus mode");
   a_switch_held: assert property (cap_cnt_ff == 2'h2 |->
      $stable(ieee_en_ff) && $stable(ieee_addr_ff))
      else $error("switch outputs changed while running");
endmodule

//--- test/scp_host_model.sv
// Host-side serial port model: 8N1 sender honouring hold-off, byte receiver
`timescale 1ns/1ps
module scp_host_model #(
   parameter int unsigned BIT_CYC = 8
) (
   // Clock
   input  wire logic clk,
   // Serial lines seen from the host
   input  wire logic dtr,
   input  wire logic txd,
   output logic      rxd
);
   logic [7:0] rx_q[$];
   initial begin
      rxd = 1'b1;
   end
   // Ignoring the hold-off is only for the overrun scenario
   task automatic send(input logic [7:0] b, input bit ign);
      int i;
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (i = 0; i < 20000 && dtr === 1'b1 && !ign; i++) begin
         @(posedge clk);
      end
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         rxd <= f[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
   endtask
   // Samples each bit near its middle
   initial begin : rx_loop
      logic [7:0] d;
      forever begin
         @(posedge clk);
         if (txd === 1'b0) begin
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int k = 0; k < 8; k++) begin
               repeat (BIT_CYC) @(posedge clk);
               d[k] = txd;
            end
            repeat (BIT_CYC) @(posedge clk);
            rx_q.push_back(d);
         end
      end
   end
endmodule

//--- test/tb_top.sv
// Testbench: serial command port driven over AXI4-Lite and a host serial model
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb_top;
   localparam int unsigned BC  = 8;
   localparam logic [1:0]  OK  = scp_pkg::AXI_OKAY;
   localparam logic [1:0]  ERR = scp_pkg::AXI_SLVERR;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        sel = 1'b0;
   logic [4:0]  addr = 5'h0A;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [7:0]  awa = 8'h0, ara = 8'h0;
   logic [31:0] wd = 32'h0, last_rd, rd;
   logic        awrdy, wrdy, bv, arrdy, rv, txd, dtr, rxd, ien, irq;
   logic [1:0]  br, rr;
   logic [4:0]  iad;
   logic [15:0] derr;
   int          n_mismatch = 0;
   int          num_checks = 0;
   always #12.5 clk = ~clk;
   scp_top #(.BIT_CYC(BC)) DUT (
      .clk(clk), .rst(rst), .ce(1'b1), .rxd(rxd), .txd_ff(txd), .dtr_ff(dtr),
      .sw_sel_ieee(sel), .sw_addr(addr), .ieee_en_ff(ien), .ieee_addr_ff(iad),
      .disp_err_ff(derr), .irq_ff(irq), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
      .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr));
   scp_host_model #(.BIT_CYC(BC)) u_host (.clk(clk), .dtr(dtr), .txd(txd), .rxd(rxd));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic timeout;
      n_mismatch++;
      $display("MISMATCH wait exp answer got none");
      print_verdict();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv  <= 1'b1;
      wd  <= d;
      bry <= 1'b1;
      for (i = 0; i < 100 && !bv; i++) begin
         @(posedge clk);
         if (awv && awrdy) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end
      bry <= 1'b0;
      if (i == 100) timeout();
      `CHK("bresp", er, br)
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er, input bit chk);
      int i;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      for (i = 0; i < 100 && !rv; i++) begin
         @(posedge clk);
         if (arv && arrdy) arv <= 1'b0;
      end
      rry <= 1'b0;
      if (i == 100) timeout();
      last_rd = rd;
      if (chk) `CHK(n, e, rd)
      if (chk) `CHK("rresp", er, rr)
   endtask
   task automatic send(input string s);
      for (int k = 0; k < s.len(); k++) u_host.send(s[k], 1'b0);
      u_host.send(scp_pkg::CH_LF, 1'b0);
      repeat (20) @(posedge clk);
   endtask
   task automatic wait_dtr(input logic v);
      int i;
      for (i = 0; i < 300 && dtr !== v; i++) @(posedge clk);
      `CHK("dtr", v, dtr)
   endtask
   task automatic t_cfg;
      rdc("cfg", scp_pkg::REG_CFG, 32'h0A, OK, 1);
      `CHK("ieee_addr", 5'h0A, iad)
      sel  <= 1'b1;
      addr <= 5'h15;
      rdc("cfg_held", scp_pkg::REG_CFG, 32'h0A, OK, 1);
      `CHK("ieee_en", 1'b0, ien)
      rdc("unmapped", 8'h28, 32'h0, ERR, 1);
      wr(8'h28, 32'h1, ERR);
   endtask
   task automatic t_cmd;
      send("AB");
      wait_dtr(1'b1);
      rdc("cmdlen", scp_pkg::REG_CMDLEN, 32'h2, OK, 1);
      rdc("cmd0", scp_pkg::REG_CMDDAT, 32'h41, OK, 1);
      rdc("cmd1", scp_pkg::REG_CMDDAT, 32'h42, OK, 1);
      rdc("irq_stat", scp_pkg::REG_IRQ_STAT, 32'h1, OK, 1);
      wr(scp_pkg::REG_IRQ_MASK, 32'h1, OK);
      repeat (3) @(posedge clk);
      `CHK("irq", 1'b1, irq)
      wr(scp_pkg::REG_IRQ_MASK, 32'h0, OK);
      repeat (3) @(posedge clk);
      `CHK("irq_masked", 1'b0, irq)
      wr(scp_pkg::REG_IRQ_MASK, 32'h1, OK);
      wr(scp_pkg::REG_IRQ_STAT, 32'h1, OK);
      repeat (3) @(posedge clk);
      `CHK("irq_clear", 1'b0, irq)
      `CHK("dtr_held", 1'b1, dtr)
      wr(scp_pkg::REG_CTRL, 32'h1 << scp_pkg::CTRL_DONE, OK);
      wait_dtr(1'b0);
   endtask
   task automatic t_ovr;
      int i;
      send("X");
      wait_dtr(1'b1);
      u_host.send(8'h59, 1'b1);
      for (i = 0; i < 100 && derr === 16'h0; i++) @(posedge clk);
      `CHK("disp_err", scp_pkg::ERR_COMM, derr)
      rdc("errcode", scp_pkg::REG_ERRCODE, 32'h0000FF9C, OK, 1);
      rdc("esr_ovr", scp_pkg::REG_ESR, 32'h20, OK, 1);
      wr(scp_pkg::REG_CTRL, 32'h1 << scp_pkg::CTRL_CLS, OK);
      rdc("esr_cls", scp_pkg::REG_ESR, 32'h0, OK, 1);
      rdc("err_cls", scp_pkg::REG_ERRCODE, 32'h0, OK, 1);
      `CHK("disp_cls", 16'h0, derr)
      wr(scp_pkg::REG_CTRL, 32'h1 << scp_pkg::CTRL_DONE, OK);
      wait_dtr(1'b0);
   endtask
   task automatic t_err;
      int unsigned cb[4] = '{scp_pkg::CTRL_QERR, scp_pkg::CTRL_DERR, scp_pkg::CTRL_XERR,
                             scp_pkg::CTRL_SERR};
      logic [31:0] w[4] = '{32'h04, 32'h08, 32'h10, 32'h20};
      logic [31:0] e;
      e = 32'h0;
      for (int b = 0; b < 4; b++) begin
         wr(scp_pkg::REG_CTRL, 32'h1 << cb[b], OK);
         e = e | w[b];
         rdc("esr", scp_pkg::REG_ESR, e, OK, 1);
      end
      wr(scp_pkg::REG_CTRL, 32'h1 << scp_pkg::CTRL_CLS, OK);
      rdc("esr_clr", scp_pkg::REG_ESR, 32'h0, OK, 1);
   endtask
   task automatic tx_idle;
      for (int i = 0; i < 100; i++) begin
         rdc("stat", scp_pkg::REG_STAT, 32'h0, OK, 0);
         if (last_rd[3:2] === 2'b00) break;
      end
   endtask
   task automatic t_tx;
      int i;
      u_host.rx_q.delete();
      wr(scp_pkg::REG_TXDAT, 32'h5A, OK);
      tx_idle();
      wr(scp_pkg::REG_TXDAT, {24'h0, scp_pkg::CH_CR}, OK);
      tx_idle();
      wr(scp_pkg::REG_CTRL, 32'h1 << scp_pkg::CTRL_TXEOL, OK);
      for (i = 0; i < 600 && u_host.rx_q.size() < 2; i++) @(posedge clk);
      repeat (30 * BC) @(posedge clk);
      `CHK("rx_count", 2, u_host.rx_q.size())
      `CHK("rx_byte", 8'h5A, u_host.rx_q[0])
      `CHK("rx_eol", scp_pkg::CH_LF, u_host.rx_q[1])
   endtask
   task automatic t_ieee;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rdc("cfg_bus", scp_pkg::REG_CFG, 32'h35, OK, 1);
      `CHK("ieee_on", 1'b1, ien)
      send("Q");
      `CHK("dtr_bus", 1'b0, dtr)
      rdc("cmdlen_bus", scp_pkg::REG_CMDLEN, 32'h0, OK, 1);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_cfg();
      t_cmd();
      t_ovr();
      t_err();
      t_tx();
      t_ieee();
      print_verdict();
   end
   // Cuts a hang short
   initial begin
      repeat (90000) @(posedge clk);
      timeout();
   end
endmodule
bind scp_top scp_checker #(.BIT_CYC(BIT_CYC)) u_chk (
   .clk(clk), .rst(rst), .txd_ff(txd_ff), .dtr_ff(dtr_ff), .sw_sel_ieee(sw_sel_ieee),
   .sw_addr(sw_addr), .ieee_en_ff(ieee_en_ff), .ieee_addr_ff(ieee_addr_ff),
   .disp_err_ff(disp_err_ff), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_wdata(s_axi_wdata), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));
